/* File: src/mms_core.sv */
// Serial channel core: bit-rate divider, transmit shifter, receive shifter.
// Assumes all inputs synchronous to sys_clk; f8 and f2n ticks come from outside.
`timescale 1ns/1ns
module mms_core #(
  parameter int DIV_W = 8
) (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Configuration.
  input  wire mms_pkg::mms_cfg_t     cfg,
  input  wire logic [DIV_W-1:0]      bit_rate_divider,
  input  wire logic                  f8_tick,
  input  wire logic                  f2n_tick,
  // Transmit data.
  input  wire logic [7:0]            tx_data,
  input  wire logic                  tx_write,
  // Bus condition events.
  input  wire mms_pkg::mms_bus_evt_t bus_evt,
  // Pins.
  input  wire logic                  clear_to_send_input,
  input  wire logic                  serial_rx_pin,
  output logic                       serial_tx_pin,
  output logic                       serial_clock_pin,
  output logic                       serial_clock_oe,
  // Status.
  output logic                       tx_buffer_empty_flag,
  output logic                       shift_empty_flag,
  output logic [7:0]                 rx_data,
  output logic                       rx_done,
  output logic                       irq_request_flag
);
  import mms_pkg::*;

  typedef enum logic [3:0] {
    MMS_IDLE  = 4'b0001,
    MMS_START = 4'b0010,
    MMS_DATA  = 4'b0100,
    MMS_STOP  = 4'b1000
  } mms_state_t;

  logic             active;
  logic             src_tick;
  logic [DIV_W-1:0] div_reg;
  logic             half_tick;
  logic             clk_reg;
  logic             fall;
  logic             rise;
  logic             bit_tick;
  logic [7:0]       buf_reg;
  logic             buf_full_reg;
  logic [9:0]       sh_reg;
  logic [3:0]       cnt_reg;
  logic [3:0]       frame_len;
  mms_state_t       st_reg;
  logic             tx_go;
  logic             shift_done;
  logic [7:0]       rx_sh_reg;
  logic [2:0]       rx_cnt_reg;
  logic             rx_busy_reg;

  // Mode zero holds the whole channel idle.
  assign active = (cfg.serial_mode_select != MMS_MODE_OFF);

  // Selected count source tick.
  always_comb begin
    case (cfg.count_source_select)
      MMS_SRC_F8:  src_tick = f8_tick;
      MMS_SRC_F2N: src_tick = f2n_tick;
      default:     src_tick = 1'b1;
    endcase
  end

  // Divider reloads with m so each half period is m+1 source ticks.
  // A frame start restarts it, so the first bit of a frame is never cut short.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (!active || tx_go || (src_tick && div_reg == '0)) begin
      div_reg <= bit_rate_divider;
    end else if (src_tick) begin
      div_reg <= div_reg - 1'b1;
    end
  end
  assign half_tick = active && src_tick && (div_reg == '0);

  // Bit clock toggles every half period, idling high.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_reg <= 1'b1;
    end else if (tx_go) begin
      // Asynchronous frames start low so the start bit lasts one whole period.
      clk_reg <= (cfg.serial_mode_select != MMS_MODE_UART);
    end else if (!active || st_reg == MMS_IDLE) begin
      clk_reg <= 1'b1;
    end else if (half_tick) begin
      clk_reg <= ~clk_reg;
    end
  end
  assign fall = half_tick && clk_reg;
  assign rise = half_tick && !clk_reg;
  // Transmit data changes on the falling edge of the internal clock; polarity only inverts the pin.
  assign bit_tick = fall;

  // Internal clock drives the pin only when direction is zero.
  assign serial_clock_pin = cfg.clock_polarity_select ? ~clk_reg : clk_reg;
  assign serial_clock_oe  = active && !cfg.clock_source_direction;

  // Transmit start needs enable, data and, when handshake is on, a low CTS.
  assign tx_go = active && cfg.transmit_enable_bit && buf_full_reg &&
                 (cfg.handshake_disable || !clear_to_send_input) && st_reg == MMS_IDLE;

  // Frame length: 8 data, optional parity, one or two stops in UART mode.
  always_comb begin
    frame_len = 4'(MMS_DATA_BITS);
    if (cfg.serial_mode_select == MMS_MODE_UART) begin
      frame_len = 4'(MMS_DATA_BITS) + 4'(cfg.parity_enable) + 4'(cfg.stop_bit_select);
    end
  end

  // Transmit buffer, refilled by writes, drained at frame start.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buf_reg      <= 8'h00;
      buf_full_reg <= 1'b0;
    end else if (!active) begin
      buf_full_reg <= 1'b0;
    end else if (tx_write) begin
      buf_reg      <= tx_data;
      buf_full_reg <= 1'b1;
    end else if (tx_go) begin
      buf_full_reg <= 1'b0;
    end
  end
  assign tx_buffer_empty_flag = !buf_full_reg;

  // Transmit sequencer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg  <= MMS_IDLE;
      sh_reg  <= 10'h3ff;
      cnt_reg <= 4'h0;
    end else if (!active || !cfg.transmit_enable_bit) begin
      st_reg  <= MMS_IDLE;
      sh_reg  <= 10'h3ff;
    end else begin
      case (st_reg)
        MMS_IDLE: if (tx_go) begin
          // Clocked frames keep the line idle until the first falling edge shifts bit 0 out.
          if (cfg.serial_mode_select != MMS_MODE_UART) begin
            sh_reg <= {1'b1, buf_reg, 1'b1};
          end else if (cfg.parity_enable) begin
            sh_reg <= {1'b1, ^buf_reg, buf_reg};
          end else begin
            sh_reg <= {2'b11, buf_reg};
          end
          cnt_reg <= 4'h0;
          st_reg  <= (cfg.serial_mode_select == MMS_MODE_UART) ? MMS_START : MMS_DATA;
        end
        MMS_START: if (bit_tick) begin
          st_reg <= MMS_DATA;
        end
        MMS_DATA: if (bit_tick) begin
          sh_reg  <= {1'b1, sh_reg[9:1]};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == frame_len - 4'h1) begin
            st_reg <= MMS_STOP;
          end
        end
        MMS_STOP: if (bit_tick) begin
          st_reg <= MMS_IDLE;
          sh_reg <= 10'h3ff;
        end
        default: st_reg <= MMS_IDLE;
      endcase
    end
  end
  assign shift_done = (st_reg == MMS_STOP) && bit_tick;

  // Transmit pin output, low bit during start.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_tx_pin <= 1'b1;
    end else begin
      serial_tx_pin <= (st_reg == MMS_START) ? 1'b0 : sh_reg[0];
    end
  end

  // Shift empty when idle with nothing pending.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_empty_flag <= 1'b1;
    end else begin
      shift_empty_flag <= (st_reg == MMS_IDLE) && !buf_full_reg && !tx_write;
    end
  end

  // Receive shifter is armed at frame start and takes eight samples on the edge opposite the data change.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sh_reg   <= 8'h00;
      rx_cnt_reg  <= 3'h0;
      rx_busy_reg <= 1'b0;
      rx_data     <= 8'h00;
      rx_done     <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!active || !cfg.receive_enable_bit) begin
        rx_cnt_reg  <= 3'h0;
        rx_busy_reg <= 1'b0;
      end else if (tx_go) begin
        rx_cnt_reg  <= 3'h0;
        rx_busy_reg <= 1'b1;
      end else if (rx_busy_reg && rise && st_reg != MMS_START) begin
        rx_sh_reg  <= {serial_rx_pin, rx_sh_reg[7:1]};
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == 3'h7) begin
          rx_data     <= {serial_rx_pin, rx_sh_reg[7:1]};
          rx_done     <= 1'b1;
          rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Interrupt request pulse per mode.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_request_flag <= 1'b0;
    end else if (!active) begin
      irq_request_flag <= 1'b0;
    end else if (cfg.serial_mode_select == MMS_MODE_I2C) begin
      irq_request_flag <= |bus_evt;
    end else begin
      irq_request_flag <= cfg.tx_irq_cause_select ? shift_done : (tx_go || rx_done);
    end
  end

  // Transmit request follows the buffer emptying when cause select is zero.
  a_tx_irq_empty: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tx_go && !cfg.tx_irq_cause_select && cfg.serial_mode_select != MMS_MODE_I2C) |=> irq_request_flag)
    else $error("transmit irq missing");
  a_mode_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!active) |-> (st_reg == MMS_IDLE || $past(active)) && !serial_clock_oe)
    else $error("channel active in mode zero");
  a_cts_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_reg == MMS_IDLE && !cfg.handshake_disable && clear_to_send_input) |=> st_reg == MMS_IDLE)
    else $error("frame began without clear to send");
  a_tx_disable: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!cfg.transmit_enable_bit) |=> st_reg == MMS_IDLE)
    else $error("transmit ran while disabled");
  a_clk_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_clock_oe == (active && !cfg.clock_source_direction))
    else $error("clock direction wrong");
  a_bus_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active && cfg.serial_mode_select == MMS_MODE_I2C && |bus_evt) |=> irq_request_flag)
    else $error("bus event irq missing");
  a_half_period: assert property (@(posedge sys_clk) disable iff (!resetn)
    (half_tick && cfg.count_source_select == MMS_SRC_F1 && $stable(bit_rate_divider) && active &&
     bit_rate_divider != '0)
      |=> !half_tick [*1])
    else $error("divider period too short");
  a_shift_empty: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_reg != MMS_IDLE) |=> !shift_empty_flag)
    else $error("shift empty during frame");
  a_tx_edge: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_reg == MMS_DATA && !cfg.clock_polarity_select && rise) |=> $stable(cnt_reg))
    else $error("data changed on rising edge");
endmodule

/* File: common/mms_pkg.sv */
// Package for the multi-mode serial interface: mode codes, field layouts,
// reset values and carrier structs. Assumes one synchronous clock domain.
// Functional notes
// - Bit clock period is two times divider value plus one count source ticks.
// - Clock direction zero means the bit clock is made internally.
// - Handshake disable zero enables clear-to-send gating of transmission.
// - Polarity zero changes transmit data on the falling clock edge.
// - Cause select zero raises transmit request when the buffer empties.
// - Mode select value zero disables the whole serial interface.
// - Transmit and receive each run only while their enable bit is one.
// - Bus mode raises requests on start, stop, ack or rx done, nack or tx done.
// - Asynchronous mode uses eight data bits, optional parity, one or two stops.
package mms_pkg;
  localparam logic [2:0] MMS_MODE_OFF  = 3'h0;
  localparam logic [2:0] MMS_MODE_SYNC = 3'h1;
  localparam logic [2:0] MMS_MODE_I2C  = 3'h2;
  localparam logic [2:0] MMS_MODE_UART = 3'h5;
  localparam logic [1:0] MMS_SRC_F1    = 2'h0;
  localparam logic [1:0] MMS_SRC_F8    = 2'h1;
  localparam logic [1:0] MMS_SRC_F2N   = 2'h2;
  localparam int         MMS_DATA_BITS = 8;
  localparam logic [7:0] MMS_DIV_RST   = 8'h00;

  typedef struct packed {
    logic [2:0] serial_mode_select;
    logic       clock_source_direction;
    logic       parity_enable;
    logic       stop_bit_select;
    logic       handshake_disable;
    logic       clock_polarity_select;
    logic       tx_irq_cause_select;
    logic [1:0] count_source_select;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
  } mms_cfg_t;

  typedef struct packed {
    logic start_det;
    logic stop_det;
    logic ack_or_rx_done;
    logic nack_or_tx_done;
  } mms_bus_evt_t;
endpackage

/* File: sim/mms_peer.sv */
// Serial peer model: clear-to-send level and a looped-back receive line.
// Assumes the bench decides when the peer is ready to take data.
`timescale 1ns/1ns
module mms_peer (
  // Control from the bench.
  input  wire logic ready,
  // Channel pins.
  input  wire logic serial_tx_pin,
  output logic      clear_to_send_input,
  output logic      serial_rx_pin
);
  // A ready peer pulls the active-low clear-to-send line down.
  assign clear_to_send_input = ~ready;
  // The receive line returns the inverse of what is sent, so a stuck line cannot pass.
  assign serial_rx_pin = ~serial_tx_pin;
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the serial channel core with a peer model.
// Assumes f8 and f2n ticks are made here, every eighth and fourth clock.
`timescale 1ns/1ns
module testbench;
  import mms_pkg::*;
  logic         sys_clk  = 1'b0;
  logic         resetn   = 1'b0;
  logic         f8_tick  = 1'b0;
  logic         f2n_tick = 1'b0;
  logic         tx_write = 1'b0;
  logic         ready    = 1'b1;
  logic [7:0]   tx_data  = 8'h00;
  logic [7:0]   div      = 8'h01;
  mms_cfg_t     cfg      = '0;
  mms_bus_evt_t evt      = '0;
  logic [7:0]   rx_data, got;
  logic         tx_pin, rx_pin, cts_n, clk_pin, clk_oe, tbe, sef, rx_done, irq;
  int           failures = 0;
  int           compares = 0;
  int           tick_cnt = 0;
  int           at, n;

  always #5 sys_clk = ~sys_clk;
  // Count source pulses off the falling edge.
  always @(negedge sys_clk) begin
    tick_cnt <= tick_cnt + 1;
    f8_tick  <= (tick_cnt % 8) == 7;
    f2n_tick <= (tick_cnt % 4) == 3;
  end

  mms_core i_dut (.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .bit_rate_divider(div),
    .f8_tick(f8_tick), .f2n_tick(f2n_tick), .tx_data(tx_data), .tx_write(tx_write),
    .bus_evt(evt), .clear_to_send_input(cts_n), .serial_rx_pin(rx_pin),
    .serial_tx_pin(tx_pin), .serial_clock_pin(clk_pin), .serial_clock_oe(clk_oe),
    .tx_buffer_empty_flag(tbe), .shift_empty_flag(sef), .rx_data(rx_data),
    .rx_done(rx_done), .irq_request_flag(irq));
  mms_peer i_peer (.ready(ready), .serial_tx_pin(tx_pin), .clear_to_send_input(cts_n),
    .serial_rx_pin(rx_pin));

  // Comparison and verdict.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits for the clock pin (w=0) or data pin (w=1) to reach lvl, counting clocks.
  task automatic wait_edge(input int w, input logic lvl, input int lim, output int cnt);
    logic last;
    cnt = 0;
    do begin
      last = w ? tx_pin : clk_pin;
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > lim) begin
        check(8'h00, 8'h01);
        end_sim();
      end
    end while (!(last !== lvl && (w ? tx_pin : clk_pin) === lvl));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // Loads one byte and notes the clock after the write edge where the request shows.
  // Returns before the first bit clock edge of a frame that starts at once.
  task automatic send(input logic [7:0] d, output int a);
    a = -1;
    @(negedge sys_clk);
    tx_data = d;
    tx_write = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      if (irq === 1'b1) a = i;
      @(negedge sys_clk);
      tx_write = 1'b0;
    end
  endtask
  task automatic idle_wait();
    wait_edge(0, 1'b1, 200, n);
    for (int i = 0; i < 300 && sef !== 1'b1; i++) cyc(1);
    check({tbe, sef}, 8'h03);
  endtask
  task automatic set_mode(input logic [2:0] m, input logic en);
    @(negedge sys_clk);
    cfg.serial_mode_select = m;
    cfg.transmit_enable_bit = en;
    cfg.receive_enable_bit = en;
  endtask

  // Synchronous frame: request timing, bit order, data edge, loop-back receive.
  task automatic s_sync();
    send(8'hA5, at);
    check(at[7:0], 8'h01);
    check(clk_oe, 1'b1);
    for (int b = 0; b < 8; b++) begin
      wait_edge(0, 1'b1, 40, n);
      got[b] = tx_pin;
    end
    check(got, 8'hA5);
    idle_wait();
    check(rx_data, 8'h5A);
  endtask
  // Inverted clock: the pin falls where the peer samples, data still one bit per period.
  task automatic s_pol();
    @(negedge sys_clk);
    cfg.clock_polarity_select = 1'b1;
    send(8'hC3, at);
    for (int b = 0; b < 8; b++) begin
      wait_edge(0, 1'b0, 40, n);
      got[b] = tx_pin;
    end
    check(got, 8'hC3);
    idle_wait();
    check(rx_data, 8'h3C);
    @(negedge sys_clk);
    cfg.clock_polarity_select = 1'b0;
  endtask
  // Bit period for each count source.
  task automatic s_period();
    int mult [3] = '{1, 8, 4};
    for (int s = 0; s < 3; s++) begin
      @(negedge sys_clk);
      cfg.count_source_select = s[1:0];
      send(8'h0F, at);
      wait_edge(0, 1'b0, 200, n);
      wait_edge(0, 1'b0, 200, n);
      check(n, 2 * (div + 1) * mult[s]);
      idle_wait();
    end
    cfg.count_source_select = MMS_SRC_F1;
  endtask
  // Clear-to-send holds the frame back until the peer is ready.
  task automatic s_cts();
    cfg.handshake_disable = 1'b0;
    ready = 1'b0;
    send(8'h81, at);
    check(at, -1);
    cyc(20);
    check({tbe, tx_pin}, 8'h01);
    @(negedge sys_clk);
    ready = 1'b1;
    wait_edge(0, 1'b0, 20, n);
    idle_wait();
    cfg.handshake_disable = 1'b1;
  endtask
  // Disabled transmit, mode off and the recovery sequence.
  task automatic s_gate();
    set_mode(MMS_MODE_SYNC, 1'b0);
    send(8'h33, at);
    check(at[7:0], 8'hFF);
    check(tx_pin, 1'b1);
    set_mode(MMS_MODE_OFF, 1'b0);
    cyc(2);
    check({clk_oe, tbe, tx_pin}, 8'h03);
    set_mode(MMS_MODE_SYNC, 1'b0);
    set_mode(MMS_MODE_SYNC, 1'b1);
    send(8'h66, at);
    check(at[7:0], 8'h01);
    idle_wait();
  endtask
  // Each bus condition raises one request a clock later.
  task automatic s_i2c();
    set_mode(MMS_MODE_I2C, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      evt = mms_bus_evt_t'(4'h1 << k);
      cyc(1);
      check(irq, 1'b1);
      @(negedge sys_clk);
      evt = '0;
      cyc(1);
      check(irq, 1'b0);
    end
  endtask
  // Asynchronous frame: start, eight data bits LSB first, single stop, request at the end.
  task automatic s_uart();
    set_mode(MMS_MODE_UART, 1'b1);
    cfg.tx_irq_cause_select = 1'b1;
    send(8'h3C, at);
    check(at[7:0], 8'hFF);
    check(tx_pin, 1'b0);
    wait_edge(0, 1'b0, 40, n);
    cyc(2);
    for (int b = 0; b < 8; b++) begin
      got[b] = tx_pin;
      cyc(4);
    end
    check(got, 8'h3C);
    check(tx_pin, 1'b1);
    cyc(2);
    check(irq, 1'b1);
    cyc(2);
    check(sef, 1'b1);
    @(negedge sys_clk);
    cfg.tx_irq_cause_select = 1'b0;
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    cfg.serial_mode_select = MMS_MODE_SYNC;
    cfg.handshake_disable = 1'b1;
    cfg.transmit_enable_bit = 1'b1;
    cfg.receive_enable_bit = 1'b1;
    div = 8'h01;
    // Every bit outside the defined fields stays zero.
    cfg.count_source_select = MMS_SRC_F1;
    repeat (4) @(negedge sys_clk);
    check({tx_pin, clk_pin, tbe, sef, irq}, 8'h1E);
    resetn = 1'b1;
    s_sync();
    s_pol();
    s_period();
    s_cts();
    s_gate();
    s_i2c();
    s_uart();
    end_sim();
  end
endmodule
